// [rtl/cpu_feature_debug_msr_bank.sv]
// Operation
// - Feature bit 10 set: error pin shows break events; clear: legacy error signalling.
// - Branch-trace-store-unavailable flag reads 1 when storage is absent, else 0.
// - Bit 12 reads 1: precise event sampling is not supported.
// - Bit 16 enables frequency scaling; may be built read-only.
// - Bit 23 set suppresses task priority report messages; reset value chosen.
// - Stack top register holds four-bit index of most recent branch record.
// - Debug control register steers branch and exception recording.
// - Exception target record holds last branch target before exception.
// - Exception source record holds last branch source before exception.
// - Default memory type applies where no range register matches.
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`include "msr_bank_regs.svh"

module cpu_feature_debug_msr_bank #(
    parameter logic       BTS_UNAVAILABLE   = 1'b1,
    parameter logic       FREQ_SCALE_RO     = 1'b0,
    parameter logic       FREQ_SCALE_RESET  = 1'b0,
    parameter logic       TPR_DISABLE_RESET = 1'b0,
    parameter int         RECORD_DEPTH      = 16
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset,
    // Register port
    input  wire msr_bank_pkg::reg_req_t       reg_req,
    output logic [63:0]                       reg_rdata,
    // Core events
    input  wire msr_bank_pkg::branch_event_t  branch_event,
    input  wire logic                         exception_event,
    input  wire logic                         fp_error_pending,
    input  wire logic                         break_event_pending,
    input  wire msr_bank_pkg::check_event_t   check_event,
    // Control outputs to the core
    output logic                              fp_error_pin,
    output logic                              freq_scaling_enable,
    output logic                              task_priority_report_en,
    output logic                              branch_record_enable,
    output logic [63:0]                       debug_control,
    output logic [7:0]                        default_mem_type,
    output logic [63:0]                       check_bank0_ctl
);

    // ======================================================
    // State
    logic        fp_error_mux_r,   fp_error_mux_nxt;
    logic        freq_scale_r,     freq_scale_nxt;
    logic        tpr_disable_r,    tpr_disable_nxt;
    logic [3:0]  stack_top_r,      stack_top_nxt;
    logic [63:0] debug_ctl_r,      debug_ctl_nxt;
    logic [31:0] last_source_r,    last_source_nxt;
    logic [31:0] last_target_r,    last_target_nxt;
    logic [31:0] exc_source_r,     exc_source_nxt;
    logic [31:0] exc_target_r,     exc_target_nxt;
    logic [63:0] mem_type_r,       mem_type_nxt;
    logic [63:0] check_ctl_r,      check_ctl_nxt;
    logic [63:0] check_status_r,   check_status_nxt;
    logic [63:0] rdata_r,          rdata_nxt;
    logic        fp_pin_r,         fp_pin_nxt;
    logic [63:0] misc_word;
    logic        wr_misc;
    logic        recording;

    localparam logic [3:0] LAST_INDEX = 4'(RECORD_DEPTH - 1);

    assign wr_misc   = reg_req.wr &&
                       (reg_req.addr == `OFF_MISC_FEATURE_CONTROL);
    assign recording = debug_ctl_r[`DEBUG_BIT_RECORD_EN];

    // ======================================================
    // Feature-control image; every other bit reads zero
    always_comb begin
        misc_word = `RESET_WORD;
        misc_word[`MISC_BIT_FP_ERROR_MUX]    = fp_error_mux_r;
        misc_word[`MISC_BIT_BTS_UNAVAIL]     = BTS_UNAVAILABLE;
        misc_word[`MISC_BIT_PRECISE_EVENT_SAMPLING_UNAVAIL]    = 1'b1;
        misc_word[`MISC_BIT_FREQ_SCALE_EN]   = freq_scale_r;
        misc_word[`MISC_BIT_TPR_MSG_DISABLE] = tpr_disable_r;
    end

    // ======================================================
    // Feature-control next state
    always_comb begin
        fp_error_mux_nxt = fp_error_mux_r;
        freq_scale_nxt   = freq_scale_r;
        tpr_disable_nxt  = tpr_disable_r;
        if (wr_misc) begin
            // Only the writable fields are taken; others dropped
            fp_error_mux_nxt =
                reg_req.wdata[`MISC_BIT_FP_ERROR_MUX];
            tpr_disable_nxt  =
                reg_req.wdata[`MISC_BIT_TPR_MSG_DISABLE];
            if (!FREQ_SCALE_RO) begin
                freq_scale_nxt =
                    reg_req.wdata[`MISC_BIT_FREQ_SCALE_EN];
            end
        end
    end

    // ======================================================
    // Error pin: break events or legacy error signalling
    always_comb begin
        if (fp_error_mux_r) begin
            fp_pin_nxt = break_event_pending;
        end else begin
            fp_pin_nxt = fp_error_pending;
        end
    end

    // ======================================================
    // Debug control and branch recording
    always_comb begin
        debug_ctl_nxt   = debug_ctl_r;
        stack_top_nxt   = stack_top_r;
        last_source_nxt = last_source_r;
        last_target_nxt = last_target_r;
        exc_source_nxt  = exc_source_r;
        exc_target_nxt  = exc_target_r;
        if (reg_req.wr &&
            reg_req.addr == `OFF_DEBUG_FEATURE_CONTROL) begin
            debug_ctl_nxt = reg_req.wdata;
        end
        if (recording && exception_event) begin
            // Latch the branch retired before this exception
            exc_source_nxt = last_source_r;
            exc_target_nxt = last_target_r;
        end
        if (recording && branch_event.valid) begin
            last_source_nxt = branch_event.source;
            last_target_nxt = branch_event.target;
            if (stack_top_r == LAST_INDEX) begin
                stack_top_nxt = `RESET_INDEX;
            end else begin
                stack_top_nxt = stack_top_r + `INDEX_STEP;
            end
        end
    end

    // ======================================================
    // Memory type and machine-check bank 0
    always_comb begin
        mem_type_nxt     = mem_type_r;
        check_ctl_nxt    = check_ctl_r;
        check_status_nxt = check_status_r;
        if (reg_req.wr) begin
            case (reg_req.addr)
                `OFF_DEFAULT_MEMORY_TYPE: begin
                    mem_type_nxt = reg_req.wdata;
                end
                `OFF_CHECK_BANK0_CONTROL: begin
                    check_ctl_nxt = reg_req.wdata;
                end
                `OFF_CHECK_BANK0_STATUS: begin
                    check_status_nxt = reg_req.wdata;
                end
                default: begin
                    check_status_nxt = check_status_r;
                end
            endcase
        end
        // A logged condition wins over a software write
        if (check_event.valid) begin
            check_status_nxt = check_event.status;
        end
    end

    // ======================================================
    // Read path, data one cycle after the strobe
    always_comb begin
        rdata_nxt = `RESET_WORD;
        if (reg_req.rd) begin
            case (reg_req.addr)
                `OFF_MISC_FEATURE_CONTROL: begin
                    rdata_nxt = misc_word;
                end
                `OFF_BRANCH_RECORD_STACK_TOP: begin
                    rdata_nxt = {60'h0, stack_top_r};
                end
                `OFF_DEBUG_FEATURE_CONTROL: begin
                    rdata_nxt = debug_ctl_r;
                end
                `OFF_EXCEPTION_BRANCH_TARGET: begin
                    rdata_nxt = {32'h0, exc_target_r};
                end
                `OFF_EXCEPTION_BRANCH_SOURCE: begin
                    rdata_nxt = {32'h0, exc_source_r};
                end
                `OFF_DEFAULT_MEMORY_TYPE: begin
                    rdata_nxt = mem_type_r;
                end
                `OFF_CHECK_BANK0_CONTROL: begin
                    rdata_nxt = check_ctl_r;
                end
                `OFF_CHECK_BANK0_STATUS: begin
                    rdata_nxt = check_status_r;
                end
                default: begin
                    rdata_nxt = `RESET_WORD;
                end
            endcase
        end
    end

    // ======================================================
    // Registers
    always_ff @(posedge clk) begin
        if (reset) begin
            fp_error_mux_r <= 1'b0;
            freq_scale_r   <= FREQ_SCALE_RESET;
            tpr_disable_r  <= TPR_DISABLE_RESET;
            stack_top_r    <= `RESET_INDEX;
            debug_ctl_r    <= `RESET_WORD;
            last_source_r  <= 32'h0;
            last_target_r  <= 32'h0;
            exc_source_r   <= 32'h0;
            exc_target_r   <= 32'h0;
            mem_type_r     <= `RESET_WORD;
            check_ctl_r    <= `RESET_WORD;
            check_status_r <= `RESET_WORD;
            rdata_r        <= `RESET_WORD;
            fp_pin_r       <= 1'b0;
        end else begin
            fp_error_mux_r <= fp_error_mux_nxt;
            freq_scale_r   <= freq_scale_nxt;
            tpr_disable_r  <= tpr_disable_nxt;
            stack_top_r    <= stack_top_nxt;
            debug_ctl_r    <= debug_ctl_nxt;
            last_source_r  <= last_source_nxt;
            last_target_r  <= last_target_nxt;
            exc_source_r   <= exc_source_nxt;
            exc_target_r   <= exc_target_nxt;
            mem_type_r     <= mem_type_nxt;
            check_ctl_r    <= check_ctl_nxt;
            check_status_r <= check_status_nxt;
            rdata_r        <= rdata_nxt;
            fp_pin_r       <= fp_pin_nxt;
        end
    end

    // ======================================================
    // Outputs
    assign reg_rdata               = rdata_r;
    assign fp_error_pin            = fp_pin_r;
    assign freq_scaling_enable     = freq_scale_r;
    assign task_priority_report_en = ~tpr_disable_r;
    assign branch_record_enable    = recording;
    assign debug_control           = debug_ctl_r;
    assign default_mem_type        =
        mem_type_r[`MEM_TYPE_MSB:`MEM_TYPE_LSB];
    assign check_bank0_ctl         = check_ctl_r;

endmodule // cpu_feature_debug_msr_bank

// [rtl/msr_bank_pkg.sv]
package msr_bank_pkg;

    // Software access to the bank, one strobe per cycle
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [63:0] wdata;
    } reg_req_t;

    // Branch retired by the core, with its linear addresses
    typedef struct packed {
        logic        valid;
        logic [31:0] source;
        logic [31:0] target;
    } branch_event_t;

    // Logged machine-check condition from the core
    typedef struct packed {
        logic        valid;
        logic [63:0] status;
    } check_event_t;

endpackage

// [rtl/msr_bank_regs.svh]
`ifndef MSR_BANK_REGS_SVH
`define MSR_BANK_REGS_SVH

// ==========================================================
// Register offsets
`define OFF_MISC_FEATURE_CONTROL    12'h1A0
`define OFF_BRANCH_RECORD_STACK_TOP 12'h1C9
`define OFF_DEBUG_FEATURE_CONTROL   12'h1D9
`define OFF_EXCEPTION_BRANCH_TARGET 12'h1DD
`define OFF_EXCEPTION_BRANCH_SOURCE 12'h1DE
`define OFF_DEFAULT_MEMORY_TYPE     12'h2FF
`define OFF_CHECK_BANK0_CONTROL     12'h400
`define OFF_CHECK_BANK0_STATUS      12'h401

// ==========================================================
// Feature-control field positions
`define MISC_BIT_FP_ERROR_MUX       10
`define MISC_BIT_BTS_UNAVAIL        11
`define MISC_BIT_PRECISE_EVENT_SAMPLING_UNAVAIL       12
`define MISC_BIT_FREQ_SCALE_EN      16
`define MISC_BIT_TPR_MSG_DISABLE    23

// ==========================================================
// Debug control and memory type fields
`define DEBUG_BIT_RECORD_EN         0
`define MEM_TYPE_LSB                0
`define MEM_TYPE_MSB                7

// ==========================================================
// Reset values and index step
`define RESET_WORD                  64'h0000_0000_0000_0000
`define RESET_INDEX                 4'h0
`define INDEX_STEP                  4'h1

`endif

// [tb/cpu_feature_debug_msr_bank_bench.sv]
`timescale 1ns/1ns
module cpu_feature_debug_msr_bank_bench;
    logic                        clk;
    logic                        reset;
    msr_bank_pkg::reg_req_t      req;
    logic [63:0]                 rdata;
    msr_bank_pkg::branch_event_t br;
    msr_bank_pkg::check_event_t  mc;
    logic                        exc;
    logic                        fpe;
    logic                        brk;
    logic                        pin;
    logic                        freq;
    logic                        tpr;
    int                          fails;
    int                          samples_checked;
    logic [11:0] offs [9] = '{12'h1A0, 12'h1C9, 12'h1D9, 12'h1DD,
        12'h1DE, 12'h2FF, 12'h400, 12'h401, 12'h123};
    logic [11:0] ro [4] = '{12'h1C9, 12'h1DD, 12'h1DE, 12'h123};

    cpu_feature_debug_msr_bank u_dut (
        .clk(clk), .reset(reset), .reg_req(req), .reg_rdata(rdata),
        .branch_event(br), .exception_event(exc), .fp_error_pending(fpe),
        .break_event_pending(brk), .check_event(mc), .fp_error_pin(pin),
        .freq_scaling_enable(freq), .task_priority_report_en(tpr),
        .branch_record_enable(), .debug_control(), .default_mem_type(),
        .check_bank0_ctl()
    );

    always #5 clk = ~clk;

    // ==========================================================
    // Access tasks
    task automatic chk(input string what, input logic [63:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [63:0] v);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [63:0] exp);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 64'h0};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), rdata, exp);
    endtask
    // Branch retired, then an exception in the next cycle
    task automatic branch_exc(input logic [31:0] s, t);
        @(posedge clk);
        br <= '{valid: 1'b1, source: s, target: t};
        @(posedge clk);
        br.valid <= 1'b0;
        exc <= 1'b1;
        @(posedge clk);
        exc <= 1'b0;
    endtask
    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ==========================================================
    // Test sequence
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        req = '0;
        br = '0;
        mc = '0;
        exc = 1'b0;
        fpe = 1'b0;
        brk = 1'b0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        foreach (offs[i]) rd(offs[i], i == 0 ? 64'h1800 : 64'h0);
        foreach (ro[i]) wr(ro[i], '1);
        foreach (ro[i]) rd(ro[i], 64'h0);
        wr(12'h1A0, '1);
        rd(12'h1A0, 64'h0081_1C00);
        chk("freq", {63'h0, freq}, 64'h1);
        chk("tpr", {63'h0, tpr}, 64'h0);
        @(posedge clk);
        brk <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("pin mux", {63'h0, pin}, 64'h1);
        wr(12'h1A0, 64'h0);
        brk <= 1'b0;
        fpe <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("pin legacy", {63'h0, pin}, 64'h1);
        chk("tpr off", {63'h0, tpr}, 64'h1);
        rd(12'h1A0, 64'h1800);
        wr(12'h1D9, 64'h1);
        wr(12'h2FF, 64'h06);
        rd(12'h1D9, 64'h1);
        rd(12'h2FF, 64'h06);
        branch_exc(32'h1000_0040, 32'h2000_0080);
        rd(12'h1DE, 64'h1000_0040);
        rd(12'h1DD, 64'h2000_0080);
        rd(12'h1C9, 64'h1);
        wr(12'h1D9, 64'h0);
        branch_exc(32'h3000_0000, 32'h4000_0000);
        rd(12'h1DE, 64'h1000_0040);
        rd(12'h1C9, 64'h1);
        @(posedge clk);
        mc <= '{valid: 1'b1, status: 64'h8000_0000_0000_0011};
        @(posedge clk);
        mc.valid <= 1'b0;
        rd(12'h401, 64'h8000_0000_0000_0011);
        report_and_stop();
    end

    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        report_and_stop();
    end
endmodule // cpu_feature_debug_msr_bank_bench

// [tb/msr_bank_props.sv]
`timescale 1ns/1ns
// ==========================================================
// Port checker for the feature and debug register bank
module msr_bank_props #(
    parameter logic BTS_UNAVAILABLE   = 1'b1,
    parameter logic FREQ_SCALE_RO     = 1'b0,
    parameter logic FREQ_SCALE_RESET  = 1'b0,
    parameter logic TPR_DISABLE_RESET = 1'b0
) (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   reset,
    // Register port
    input wire msr_bank_pkg::reg_req_t reg_req,
    input wire logic [63:0]            reg_rdata,
    // Core levels and control outputs
    input wire logic                   fp_error_pending,
    input wire logic                   break_event_pending,
    input wire logic                   fp_error_pin,
    input wire logic                   freq_scaling_enable,
    input wire logic                   task_priority_report_en,
    input wire logic                   branch_record_enable,
    input wire logic [63:0]            debug_control,
    input wire logic [7:0]             default_mem_type
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic mux_r;
    logic freq_r;
    logic tpr_r;
    // Shadow of the writable feature bits
    always_ff @(posedge clk) begin
        if (reset) begin
            mux_r  <= 1'b0;
            freq_r <= FREQ_SCALE_RESET;
            tpr_r  <= TPR_DISABLE_RESET;
        end else if (reg_req.wr && reg_req.addr == 12'h1A0) begin
            mux_r  <= reg_req.wdata[10];
            freq_r <= FREQ_SCALE_RO ? freq_r : reg_req.wdata[16];
            tpr_r  <= reg_req.wdata[23];
        end
    end
    sequence s_wr(logic [11:0] a);
        reg_req.wr && reg_req.addr == a;
    endsequence
    sequence s_feat_rd;
        reg_req.rd && reg_req.addr == 12'h1A0;
    endsequence
    a_fp_pin_mux:
        assert property ($past(!reset) |-> fp_error_pin ==
            $past(mux_r ? break_event_pending : fp_error_pending))
        else $error("fp error pin does not follow its source");
    a_trace_flag:
        assert property (s_feat_rd |=> reg_rdata[11] == BTS_UNAVAILABLE)
        else $error("trace store flag wrong");
    a_sampling_flag:
        assert property (s_feat_rd |=> reg_rdata[12])
        else $error("sampling flag not set");
    a_reserved_zero:
        assert property (s_feat_rd |=>
            (reg_rdata & 64'hFFFF_FFFF_FF7E_E300) == 64'h0)
        else $error("reserved feature bits not zero");
    a_freq_shadow:
        assert property (freq_scaling_enable == freq_r)
        else $error("frequency scaling enable wrong");
    a_tpr_shadow:
        assert property (task_priority_report_en == !tpr_r)
        else $error("priority report enable wrong");
    a_debug_write:
        assert property (s_wr(12'h1D9) |=> debug_control ==
            $past(reg_req.wdata) && branch_record_enable ==
            $past(reg_req.wdata[0]))
        else $error("debug control write lost");
    a_memtype_write:
        assert property (s_wr(12'h2FF) |=>
            default_mem_type == $past(reg_req.wdata[7:0]))
        else $error("default memory type write lost");
endmodule // msr_bank_props

bind cpu_feature_debug_msr_bank msr_bank_props #(
    .BTS_UNAVAILABLE(BTS_UNAVAILABLE), .FREQ_SCALE_RO(FREQ_SCALE_RO),
    .FREQ_SCALE_RESET(FREQ_SCALE_RESET),
    .TPR_DISABLE_RESET(TPR_DISABLE_RESET)
) u_props (.clk, .reset, .reg_req, .reg_rdata, .fp_error_pending,
    .break_event_pending, .fp_error_pin, .freq_scaling_enable,
    .task_priority_report_en, .branch_record_enable, .debug_control,
    .default_mem_type);
